// *** design/vsf_pkg.sv ***
// shared constants for the vendor sub-function handler
package vsf_pkg;

  // frame header values
  localparam logic [7:0] FUNC_CODE     = 8'h46;
  localparam logic [7:0] FUNC_EXC      = 8'hc6;
  localparam logic [7:0] ADDR_MIN      = 8'h01;
  localparam logic [7:0] ADDR_MAX      = 8'hf7;

  // sub-function codes
  localparam logic [7:0] SUB_FW_VER    = 8'h20;
  localparam logic [7:0] SUB_EDGE_WR   = 8'h21;
  localparam logic [7:0] SUB_EDGE_RD   = 8'h22;
  localparam logic [7:0] SUB_PON_WR    = 8'h27;
  localparam logic [7:0] SUB_PON_RD    = 8'h28;

  // payload limits and answers
  localparam logic [7:0] EDGE_MAX      = 8'h0f;
  localparam logic [7:0] STATUS_OK     = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC  = 8'h01;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

  // byte positions within a frame
  localparam int BYTE_ADDR = 0;
  localparam int BYTE_FUNC = 1;
  localparam int BYTE_SUB  = 2;
  localparam int BYTE_DATA = 3;
  localparam int BYTE_MIN  = 4;
  localparam int BYTE_BLD  = 5;

  // frame lengths
  localparam logic [3:0] REQ_LEN_HDR  = 4'h3;
  localparam logic [3:0] REQ_LEN_DATA = 4'h4;
  localparam logic [2:0] REP_LEN_VER  = 3'h6;
  localparam logic [2:0] REP_LEN_ONE  = 3'h4;
  localparam logic [2:0] REP_LEN_EXC  = 3'h3;
  localparam int         REP_BYTES    = 6;
  localparam int         REQ_BYTES    = 8;

  // settings store
  localparam int         EDGE_CH      = 4;
  localparam int         OUT_W_DEF    = 4;
  localparam logic [3:0] EDGE_RST     = 4'h0;
  localparam logic [7:0] PON_RST      = 8'h00;
  localparam logic       NV_SEL_EDGE  = 1'b0;
  localparam logic       NV_SEL_PON   = 1'b1;
  localparam logic [1:0] NV_SETTLE    = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } hstate_t;

endpackage : vsf_pkg

// *** design/vsf_frame_collect.sv ***
// gathers the bytes of one received request frame
`timescale 1ns/1ps
module vsf_frame_collect #(
  parameter int MAXB = vsf_pkg::REQ_BYTES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  byte_vld,
  input  wire logic [7:0]            byte_dat,
  input  wire logic                  frm_end,
  input  wire logic                  frm_abort,
  output logic                       done,
  output logic [3:0]                 len,
  output logic [MAXB-1:0][7:0]       bytes
);
  import vsf_pkg::*;

  initial begin
    if (MAXB < 4 || MAXB > 15) begin
      $error("vsf_frame_collect: MAXB must be 4..15");
    end
  end

  typedef struct packed {
    logic [MAXB-1:0][7:0] buf_b;
    logic [3:0]           cnt;
    logic                 done;
    logic [3:0]           len;
  } col_t;

  col_t s_q;
  col_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (frm_abort) begin
      s_d.cnt = 4'h0;
    end else if (frm_end) begin
      s_d.done = 1'b1;
      s_d.len  = s_q.cnt;
      s_d.cnt  = 4'h0;
    end else if (byte_vld) begin
      // bytes past the store are counted so the length check catches them
      for (int i = 0; i < MAXB; i++) begin
        if (s_q.cnt == 4'(i)) begin
          s_d.buf_b[i] = byte_dat;
        end
      end
      if (s_q.cnt != 4'hf) begin
        s_d.cnt = 4'(s_q.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done  = s_q.done;
  assign len   = s_q.len;
  assign bytes = s_q.buf_b;

endmodule : vsf_frame_collect

// *** design/vsf_setting_store.sv ***
// edge and power-on settings with non-volatile load and write-back
`timescale 1ns/1ps
module vsf_setting_store #(
  parameter int OUT_W = vsf_pkg::OUT_W_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [3:0]         nv_edge_in,
  input  wire logic [7:0]         nv_pon_in,
  input  wire logic               wr_edge,
  input  wire logic               wr_pon,
  input  wire logic [7:0]         wr_val,
  output logic                    ready,
  output logic [3:0]              edge_sel,
  output logic [OUT_W-1:0]        pon_val,
  output logic [OUT_W-1:0]        dout,
  output logic                    nv_stb,
  output logic                    nv_sel,
  output logic [7:0]              nv_data
);
  import vsf_pkg::*;

  typedef struct packed {
    logic [3:0]       e1;
    logic [3:0]       e2;
    logic [7:0]       p1;
    logic [7:0]       p2;
    logic [1:0]       settle;
    logic             ready;
    logic [3:0]       edge_sel;
    logic [OUT_W-1:0] pon;
    logic [OUT_W-1:0] dout;
    logic             stb;
    logic             sel;
    logic [7:0]       data;
  } sto_t;

  sto_t s_q;
  sto_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.e1  = nv_edge_in;
    s_d.e2  = s_q.e1;
    s_d.p1  = nv_pon_in;
    s_d.p2  = s_q.p1;
    s_d.stb = 1'b0;
    if (!s_q.ready) begin
      // wait until the synchronisers hold settled stored values
      if (s_q.settle == NV_SETTLE) begin
        s_d.ready    = 1'b1;
        s_d.edge_sel = s_q.e2;
        s_d.pon      = s_q.p2[OUT_W-1:0];
        s_d.dout     = s_q.p2[OUT_W-1:0];
      end else begin
        s_d.settle = 2'(s_q.settle + 2'h1);
      end
    end else if (wr_edge) begin
      s_d.edge_sel = wr_val[3:0];
      s_d.stb      = 1'b1;
      s_d.sel      = NV_SEL_EDGE;
      s_d.data     = wr_val;
    end else if (wr_pon) begin
      // live outputs keep their value; the new one applies next power-up
      s_d.pon  = wr_val[OUT_W-1:0];
      s_d.stb  = 1'b1;
      s_d.sel  = NV_SEL_PON;
      s_d.data = wr_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.edge_sel <= EDGE_RST;
      s_q.pon      <= PON_RST[OUT_W-1:0];
      s_q.dout     <= PON_RST[OUT_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign ready    = s_q.ready;
  assign edge_sel = s_q.edge_sel;
  assign pon_val  = s_q.pon;
  assign dout     = s_q.dout;
  assign nv_stb   = s_q.stb;
  assign nv_sel   = s_q.sel;
  assign nv_data  = s_q.data;

endmodule : vsf_setting_store

// *** design/vsf_handler.sv ***
// vendor function 0x46 request handler: decode, settings, reply bytes
`timescale 1ns/1ps
module vsf_handler #(
  parameter int         OUT_W     = vsf_pkg::OUT_W_DEF,
  parameter logic [7:0] VER_MAJOR = 8'h01, // arbitrary value
  parameter logic [7:0] VER_MINOR = 8'h00, // arbitrary value
  parameter logic [7:0] VER_BUILD = 8'h00  // arbitrary value
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RESETN,
  input  wire logic [7:0]       MY_ADDR,
  input  wire logic             RX_VALID,
  input  wire logic [7:0]       RX_DATA,
  input  wire logic             RX_EOF,
  input  wire logic             RX_ERR,
  output logic                  TX_VALID,
  output logic [7:0]            TX_DATA,
  output logic                  TX_LAST,
  input  wire logic             TX_READY,
  output logic                  BUSY,
  output logic [3:0]            EDGE_SEL,
  output logic [OUT_W-1:0]      PON_VALUE,
  output logic [OUT_W-1:0]      DO_OUT,
  input  wire logic [3:0]       NV_EDGE_IN,
  input  wire logic [7:0]       NV_PON_IN,
  output logic                  NV_WR_STB,
  output logic                  NV_WR_SEL,
  output logic [7:0]            NV_WR_DATA
);
  import vsf_pkg::*;

  initial begin
    if (OUT_W != 4 && OUT_W != 7) begin
      $error("vsf_handler: OUT_W must be 4 or 7");
    end
  end

  // the stores and indices are sized for the documented frames
  initial begin
    if (int'(REP_LEN_VER) > REP_BYTES) begin
      $error("vsf_handler: reply store shorter than version reply");
    end
    if (REP_BYTES > 7) begin
      $error("vsf_handler: reply index is only three bits wide");
    end
    if (int'(REQ_LEN_DATA) > REQ_BYTES) begin
      $error("vsf_handler: request store shorter than data request");
    end
    if (REQ_BYTES > 15) begin
      $error("vsf_handler: length counter holds at most 15 bytes");
    end
    if (REP_LEN_EXC < 3'h2) begin
      $error("vsf_handler: replies must be longer than one byte");
    end
  end

  localparam logic [7:0] PON_MAX = 8'((1 << OUT_W) - 1);

  typedef struct packed {
    hstate_t                   st;
    logic [REP_BYTES-1:0][7:0] rep;
    logic [2:0]                rep_len;
    logic                      load;
    logic                      busy;
    logic                      wr_edge;
    logic                      wr_pon;
    logic [7:0]                wr_val;
    logic                      tx_vld;
    logic [7:0]                tx_dat;
    logic                      tx_last;
    logic [2:0]                tx_idx;
  } hnd_t;

  hnd_t s_q;
  hnd_t s_d;

  logic                      frm_done;
  logic [3:0]                frm_len;
  logic [REQ_BYTES-1:0][7:0] frm;
  logic                      sto_ready;
  logic [3:0]                edge_cur;
  logic [OUT_W-1:0]          pon_cur;
  logic [OUT_W-1:0]          dout_cur;
  logic                      nv_stb;
  logic                      nv_sel;
  logic [7:0]                nv_data;

  vsf_frame_collect #(
    .MAXB (REQ_BYTES)
  ) u_collect (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .byte_vld  (RX_VALID),
    .byte_dat  (RX_DATA),
    .frm_end   (RX_EOF),
    .frm_abort (RX_ERR),
    .done      (frm_done),
    .len       (frm_len),
    .bytes     (frm)
  );

  vsf_setting_store #(
    .OUT_W (OUT_W)
  ) u_store (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .nv_edge_in (NV_EDGE_IN),
    .nv_pon_in  (NV_PON_IN),
    .wr_edge    (s_q.wr_edge),
    .wr_pon     (s_q.wr_pon),
    .wr_val     (s_q.wr_val),
    .ready      (sto_ready),
    .edge_sel   (edge_cur),
    .pon_val    (pon_cur),
    .dout       (dout_cur),
    .nv_stb     (nv_stb),
    .nv_sel     (nv_sel),
    .nv_data    (nv_data)
  );

  // true when the request has exactly the expected number of bytes
  function automatic logic len_ok(input logic [3:0] got,
                                  input logic [3:0] want);
    len_ok = (got == want);
  endfunction : len_ok

  // request addressed to this module with a plausible station number
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] mine);
    addr_hit = (a == mine) && (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction : addr_hit

  always_comb begin
    logic       exc;
    logic [7:0] exc_code;
    logic [7:0] sub;
    exc      = 1'b0;
    exc_code = EXC_BAD_FUNC;
    sub      = frm[BYTE_SUB];
    s_d         = s_q;
    s_d.load    = 1'b0;
    s_d.wr_edge = 1'b0;
    s_d.wr_pon  = 1'b0;

    case (s_q.st)
      ST_IDLE: begin
        // frames that are not ours, or arrive during start-up, are dropped
        if (frm_done && sto_ready && frm_len >= REQ_LEN_HDR &&
            addr_hit(frm[BYTE_ADDR], MY_ADDR) &&
            frm[BYTE_FUNC] == FUNC_CODE) begin
          s_d.rep            = '0;
          s_d.rep[BYTE_ADDR] = frm[BYTE_ADDR];
          s_d.rep[BYTE_FUNC] = FUNC_CODE;
          s_d.rep[BYTE_SUB]  = sub;
          s_d.rep_len        = REP_LEN_ONE;

          case (sub)
            SUB_FW_VER: begin
              if (len_ok(frm_len, REQ_LEN_HDR)) begin
                s_d.rep[BYTE_DATA] = VER_MAJOR;
                s_d.rep[BYTE_MIN]  = VER_MINOR;
                s_d.rep[BYTE_BLD]  = VER_BUILD;
                s_d.rep_len        = REP_LEN_VER;
              end else begin
                exc      = 1'b1;
                exc_code = EXC_BAD_VALUE;
              end
            end

            SUB_EDGE_WR: begin
              if (len_ok(frm_len, REQ_LEN_DATA) &&
                  frm[BYTE_DATA] <= EDGE_MAX) begin
                s_d.wr_edge        = 1'b1;
                s_d.wr_val         = frm[BYTE_DATA];
                s_d.rep[BYTE_DATA] = STATUS_OK;
              end else begin
                exc      = 1'b1;
                exc_code = EXC_BAD_VALUE;
              end
            end

            SUB_EDGE_RD: begin
              if (len_ok(frm_len, REQ_LEN_HDR)) begin
                s_d.rep[BYTE_DATA] = {4'h0, edge_cur};
              end else begin
                exc      = 1'b1;
                exc_code = EXC_BAD_VALUE;
              end
            end

            SUB_PON_WR: begin
              if (len_ok(frm_len, REQ_LEN_DATA) &&
                  frm[BYTE_DATA] <= PON_MAX) begin
                s_d.wr_pon         = 1'b1;
                s_d.wr_val         = frm[BYTE_DATA];
                s_d.rep[BYTE_SUB]  = SUB_PON_RD;
                s_d.rep[BYTE_DATA] = STATUS_OK;
              end else begin
                exc      = 1'b1;
                exc_code = EXC_BAD_VALUE;
              end
            end

            SUB_PON_RD: begin
              if (len_ok(frm_len, REQ_LEN_HDR)) begin
                s_d.rep[BYTE_DATA] = 8'(pon_cur);
              end else begin
                exc      = 1'b1;
                exc_code = EXC_BAD_VALUE;
              end
            end

            default: begin
              exc      = 1'b1;
              exc_code = EXC_BAD_FUNC;
            end
          endcase

          // an exception cancels the store write and shortens the reply
          if (exc) begin
            s_d.wr_edge        = 1'b0;
            s_d.wr_pon         = 1'b0;
            s_d.rep[BYTE_FUNC] = FUNC_EXC;
            s_d.rep[BYTE_SUB]  = exc_code;
            s_d.rep[BYTE_DATA] = 8'h00;
            s_d.rep_len        = REP_LEN_EXC;
          end
          s_d.load = 1'b1;
          s_d.busy = 1'b1;
          s_d.st   = ST_SEND;
        end
      end

      ST_SEND: begin
        if (s_q.load) begin
          // first byte presented the cycle after the reply is built
          s_d.tx_vld  = 1'b1;
          s_d.tx_dat  = s_q.rep[0];
          s_d.tx_last = 1'b0;
          s_d.tx_idx  = 3'h1;
        end else if (s_q.tx_vld && TX_READY) begin
          if (s_q.tx_last) begin
            s_d.tx_vld  = 1'b0;
            s_d.tx_last = 1'b0;
            s_d.busy    = 1'b0;
            s_d.st      = ST_IDLE;
          end else begin
            // rep_len never exceeds REP_BYTES, so the mux stays in range
            for (int i = 0; i < REP_BYTES; i++) begin
              if (s_q.tx_idx == 3'(i)) begin
                s_d.tx_dat = s_q.rep[i];
              end
            end
            s_d.tx_last = (3'(s_q.tx_idx + 3'h1) == s_q.rep_len);
            s_d.tx_idx  = 3'(s_q.tx_idx + 3'h1);
          end
        end
      end

      default: begin
        s_d.st   = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q    <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // replies are never shorter than three bytes, so last is never first
  assign TX_VALID   = s_q.tx_vld;
  assign TX_DATA    = s_q.tx_dat;
  assign TX_LAST    = s_q.tx_last;
  assign BUSY       = s_q.busy;
  assign EDGE_SEL   = edge_cur;
  assign PON_VALUE  = pon_cur;
  assign DO_OUT     = dout_cur;
  assign NV_WR_STB  = nv_stb;
  assign NV_WR_SEL  = nv_sel;
  assign NV_WR_DATA = nv_data;

endmodule : vsf_handler

// *** test/vsf_handler_props.sv ***
// checker for the vendor sub-function handler ports
`timescale 1ns/1ps
module vsf_handler_props
  import vsf_pkg::*;
#(
  parameter int OUT_W = 4
) (
  input wire logic             CORE_CLK,
  input wire logic             RESETN,
  input wire logic             TX_VALID,
  input wire logic [7:0]       TX_DATA,
  input wire logic             TX_LAST,
  input wire logic             TX_READY,
  input wire logic             BUSY,
  input wire logic [3:0]       EDGE_SEL,
  input wire logic [OUT_W-1:0] PON_VALUE,
  input wire logic [OUT_W-1:0] DO_OUT,
  input wire logic             NV_WR_STB,
  input wire logic             NV_WR_SEL,
  input wire logic [7:0]       NV_WR_DATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_take;
    TX_VALID && TX_READY;
  endsequence
  sequence s_wait;
    TX_VALID && !TX_READY;
  endsequence
  sequence s_start;
    $rose(BUSY);
  endsequence
  a_tx_hold: assert property (s_wait |=> TX_VALID && $stable(TX_DATA)
    && $stable(TX_LAST)) else $error("reply byte moved while stalled");
  a_last_done: assert property (s_take ##0 TX_LAST
    |=> !TX_VALID && !BUSY)
    else $error("reply did not end after last byte");
  a_valid_busy: assert property (TX_VALID |-> BUSY)
    else $error("reply byte outside busy");
  a_reply_lead: assert property (s_start |=> TX_VALID && !TX_LAST)
    else $error("reply not started one cycle after busy");
  a_stb_single: assert property (NV_WR_STB |=> !NV_WR_STB)
    else $error("store strobe longer than one cycle");
  a_stb_busy: assert property (NV_WR_STB |-> BUSY)
    else $error("store write outside a request");
  a_edge_store: assert property (NV_WR_STB && NV_WR_SEL == NV_SEL_EDGE
    |-> EDGE_SEL == NV_WR_DATA[3:0] && NV_WR_DATA[7:4] == 4'h0)
    else $error("edge select differs from stored byte");
  a_pon_store: assert property (NV_WR_STB && NV_WR_SEL == NV_SEL_PON
    |-> PON_VALUE == NV_WR_DATA[OUT_W-1:0])
    else $error("power-on value differs from stored byte");
  a_do_steady: assert property (BUSY |=> $stable(DO_OUT))
    else $error("outputs changed by a request");
endmodule : vsf_handler_props

bind vsf_handler vsf_handler_props #(.OUT_W(OUT_W)) u_props (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .BUSY(BUSY),
  .EDGE_SEL(EDGE_SEL), .PON_VALUE(PON_VALUE), .DO_OUT(DO_OUT),
  .NV_WR_STB(NV_WR_STB), .NV_WR_SEL(NV_WR_SEL), .NV_WR_DATA(NV_WR_DATA));

// *** test/vsf_master.sv ***
// serial-line master model: request frames out, reply bytes in
`timescale 1ns/1ps
module vsf_master (
  input  wire logic clk,
  input  wire logic slow,
  output logic      rx_valid,
  output logic [7:0] rx_data,
  output logic      rx_eof,
  output logic      rx_err,
  output logic      tx_ready
);
  logic tog_q;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eof = 1'b0;
    rx_err = 1'b0;
    tog_q = 1'b0;
  end
  // slow sink is ready every other cycle to exercise stalls
  always @(posedge clk) begin
    #2;
    tog_q = ~tog_q;
  end
  assign tx_ready = slow ? tog_q : 1'b1;
  // called just after an edge; eof gets its own cycle
  task automatic send(input logic [7:0] b[4], input int n);
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data = b[i];
      @(posedge clk);
      #2;
    end
    rx_valid = 1'b0;
    rx_data = ~b[n-1];
    rx_eof = 1'b1;
    @(posedge clk);
    #2;
    rx_eof = 1'b0;
    rx_data = b[n-1];
  endtask : send
  task automatic abort(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
    rx_data = ~b;
    rx_err = 1'b1;
    @(posedge clk);
    #2;
    rx_err = 1'b0;
  endtask : abort
endmodule : vsf_master

// *** test/vsf_handler_test.sv ***
// self-checking bench for the vendor sub-function handler
`timescale 1ns/1ps
module vsf_handler_test;
  import vsf_pkg::*;
  localparam logic [7:0] A = 8'h0a;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  my_addr = A;
  logic        slow = 1'b0;
  logic [3:0]  nv_edge = 4'h5;
  logic [7:0]  nv_pon = 8'h3a;
  logic        rx_valid, rx_eof, rx_err, tx_ready, tx_valid, tx_last, busy;
  logic [7:0]  rx_data, tx_data, nv_data, v;
  logic [3:0]  edge_sel, pon_value, do_out;
  logic        nv_stb, nv_sel;
  logic [8:0]  expq[$];
  logic [8:0]  nvq[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'd11588;
  logic [7:0]  tbl[3] = '{8'h03, 8'h0f, 8'h00};

  always #12.5 clk = ~clk;

  vsf_master m (.clk(clk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_err(rx_err), .tx_ready(tx_ready));
  vsf_handler #(.OUT_W(4), .VER_MAJOR(8'h9c), .VER_MINOR(8'h03),
    .VER_BUILD(8'hff)) dut (
    .CORE_CLK(clk), .RESETN(resetn), .MY_ADDR(my_addr), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_EOF(rx_eof), .RX_ERR(rx_err),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_READY(tx_ready), .BUSY(busy), .EDGE_SEL(edge_sel),
    .PON_VALUE(pon_value), .DO_OUT(do_out), .NV_EDGE_IN(nv_edge),
    .NV_PON_IN(nv_pon), .NV_WR_STB(nv_stb), .NV_WR_SEL(nv_sel),
    .NV_WR_DATA(nv_data));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic wait_idle;
    int k = 0;
    repeat (3) @(posedge clk);
    while ((busy !== 1'b0 || expq.size() != 0) && k < 80) begin
      @(posedge clk);
      k++;
    end
    if (k >= 80) begin
      check("timeout", 16'h1, 16'h0);
      end_sim();
    end
    #2;
  endtask : wait_idle
  // reply is A, f, s, b3, b4, b5 cut to nb bytes
  task automatic req(input logic [7:0] sub, d, input int n,
                     input logic [7:0] f, s, b3, b4, b5, input int nb);
    logic [7:0] r[6];
    r = '{A, f, s, b3, b4, b5};
    for (int i = 0; i < nb; i++) expq.push_back({i == nb - 1, r[i]});
    m.send('{A, FUNC_CODE, sub, d}, n);
    wait_idle();
  endtask : req

  // unmatched or extra bytes are mismatches, order and last flag checked
  always @(negedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (expq.size() == 0) begin
        check("spare reply", {8'h0, tx_data}, 16'hffff);
      end else begin
        check("reply", {7'h0, tx_last, tx_data},
              {7'h0, expq.pop_front()});
      end
    end
    if (nv_stb === 1'b1) begin
      if (nvq.size() == 0) begin
        check("spare store", {7'h0, nv_sel, nv_data}, 16'hffff);
      end else begin
        check("store", {7'h0, nv_sel, nv_data},
              {7'h0, nvq.pop_front()});
      end
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #2;
    resetn = 1'b1;
    repeat (8) @(posedge clk);
    #2;
    check("edge start", {12'h0, edge_sel}, 16'h5);
    check("pon start", {12'h0, pon_value}, 16'ha);
    check("dout start", {12'h0, do_out}, 16'ha);
    req(SUB_FW_VER, 0, 3, FUNC_CODE, SUB_FW_VER, 8'h9c, 8'h03,
        8'hff, 6);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      slow = seed[8];
      v = (i < 3) ? tbl[i] : {4'h0, seed[3:0]};
      nvq.push_back({NV_SEL_EDGE, v});
      req(SUB_EDGE_WR, v, 4, FUNC_CODE, SUB_EDGE_WR, STATUS_OK,
          0, 0, 4);
      check("edge sel", {12'h0, edge_sel}, {8'h0, v});
      req(SUB_EDGE_RD, 0, 3, FUNC_CODE, SUB_EDGE_RD, v, 0, 0, 4);
    end
    nvq.push_back({NV_SEL_PON, 8'h0f});
    req(SUB_PON_WR, 8'h0f, 4, FUNC_CODE, SUB_PON_RD, STATUS_OK,
        0, 0, 4);
    check("pon value", {12'h0, pon_value}, 16'hf);
    check("dout kept", {12'h0, do_out}, 16'ha);
    req(SUB_PON_RD, 0, 3, FUNC_CODE, SUB_PON_RD, 8'h0f, 0, 0, 4);
    req(SUB_EDGE_WR, 8'h10, 4, FUNC_EXC, EXC_BAD_VALUE, 0, 0, 0,
        3);
    req(SUB_PON_WR, 8'h10, 4, FUNC_EXC, EXC_BAD_VALUE, 0, 0, 0,
        3);
    req(8'h23, 0, 3, FUNC_EXC, EXC_BAD_FUNC, 0, 0, 0, 3);
    req(SUB_FW_VER, 0, 4, FUNC_EXC, EXC_BAD_VALUE, 0, 0, 0, 3);
    check("edge kept", {12'h0, edge_sel}, {8'h0, v});
    check("pon kept", {12'h0, pon_value}, 16'hf);
    m.send('{8'h0b, FUNC_CODE, SUB_FW_VER, 0}, 3);
    wait_idle();
    m.send('{8'h00, FUNC_CODE, SUB_FW_VER, 0}, 3);
    wait_idle();
    m.send('{A, 8'h03, SUB_FW_VER, 0}, 3);
    wait_idle();
    m.abort(A);
    req(SUB_EDGE_RD, 0, 3, FUNC_CODE, SUB_EDGE_RD, v, 0, 0, 4);
    check("store left", 16'(nvq.size()), 16'h0);
    end_sim();
  end
endmodule : vsf_handler_test
